// file: design/facp_pkg.sv
// shared constants of the alert conditioning block
package facp_pkg;
	// register offsets and the clear faults command code
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] ADDR_BUS_STATUS = 8'h7A;
	localparam logic [7:0] ADDR_CUR_STATUS = 8'h7B;
	localparam logic [7:0] ADDR_COND_CFG = 8'hDD;
	localparam logic [7:0] ADDR_POL_FORCE = 8'hDE;
	localparam logic [7:0] ADDR_MASK_A = 8'h1B;
	localparam logic [7:0] ADDR_MASK_B = 8'hDF;
	// alert_condition_config fields
	localparam int BYPASS_B_LSB = 12;
	localparam int BYPASS_A_LSB = 9;
	localparam int OC_GLITCH_LSB = 7;
	localparam int UV_GLITCH_LSB = 5;
	localparam int OV_GLITCH_LSB = 3;
	localparam int OC_ON_BIT = 2;
	localparam int OV_ON_BIT = 1;
	localparam int UV_ON_BIT = 0;
	localparam logic [15:0] COND_CFG_WMASK = 16'h7FFF;
	// alert_polarity_force fields
	localparam int LEVEL_B_BIT = 3;
	localparam int LEVEL_A_BIT = 2;
	localparam int FORCE_B_BIT = 1;
	localparam int FORCE_A_BIT = 0;
	// status bit positions
	localparam int BUS_OV_FLAG_BIT = 6;
	localparam int BUS_UV_FLAG_BIT = 5;
	localparam int OC_FLAG_BIT = 5;
	// source index inside three-bit groups: 2 = ov, 1 = uv, 0 = oc
	localparam int SRC_OV = 2;
	localparam int SRC_UV = 1;
	localparam int SRC_OC = 0;
	// reset values
	localparam logic [15:0] COND_CFG_RESET = 16'h0000;
	localparam logic [3:0] POL_FORCE_RESET = 4'h0;
	localparam logic [2:0] MASK_RESET = 3'h7;
	localparam logic [2:0] FLAGS_RESET = 3'h0;
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int GLITCH_2US_NS = 2000;
	localparam int GLITCH_4US_NS = 4000;
	localparam int GLITCH_8US_NS = 8000;
	localparam logic [7:0] GLITCH_2US_CYC = 8'((GLITCH_2US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] GLITCH_4US_CYC = 8'((GLITCH_4US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [7:0] GLITCH_8US_CYC = 8'((GLITCH_8US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	typedef struct packed {
		logic [15:0] condCfg;
		logic [3:0] polForce;
		logic [2:0] maskA;
		logic [2:0] maskB;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0][7:0] glitchCnt;
		logic [2:0] flags;
		logic alertAOeN;
		logic alertAOut;
		logic alertB;
		logic [15:0] rdData;
	} facp_state_type;
endpackage

// file: design/facp_alert_cond.sv
// Overview of operation
// - bits 14..12 bypass filtering for alert b
// - bits 11..9 bypass filtering for alert a
// - both alerts share comparators, filters, flags
// - bits 8..7 set shared overcurrent filter
// - bits 6..5 set shared undervoltage filter
// - bits 4..3 set shared overvoltage filter
// - codes give 0, 2, 4, 8 us
// - fault passes only after full filter time
// - bit 2 enables overcurrent comparator
// - bit 1 enables overvoltage comparator
// - bit 0 enables undervoltage comparator
// - level bits pick each pin's active level
// - force bits assert pins regardless of faults
// - command 0x03 clears all status flags
// - bus overvoltage flag latches in bit 6
// - bus undervoltage flag latches in bit 5
// - writing one clears a latched flag
// - current status holds flag bit 5 only
// - overcurrent flag latches on shunt trip
// - masks default set, masked sources ignored
`timescale 1ns/1ps
module facp_alert_cond (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic overvoltCmp,
	input wire logic undervoltCmp,
	input wire logic overcurrentCmp,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic cmdStrobe,
	input wire logic [7:0] cmdCode,
	output logic [15:0] regRdData,
	output logic alertAPinOut,
	output logic alertAPinOeN,
	output logic alertBPin
);
	import facp_pkg::*;

	facp_state_type state_reg;
	facp_state_type state_next;

	logic [2:0] cmpOn;
	logic [2:0] rawFault;
	logic [2:0] filtFault;
	logic [2:0][7:0] glitchLimit;
	logic [2:0] flagW1c;
	logic clearAll;
	logic [2:0] srcA;
	logic [2:0] srcB;
	logic activeA;
	logic activeB;

	// comparator enables gate the synchronised comparator levels
	assign cmpOn[SRC_OC] = state_reg.condCfg[OC_ON_BIT];
	assign cmpOn[SRC_OV] = state_reg.condCfg[OV_ON_BIT];
	assign cmpOn[SRC_UV] = state_reg.condCfg[UV_ON_BIT];
	assign rawFault = state_reg.sync2 & cmpOn;

	// one filter per source, shared by both pins
	generate
		for (genvar i = 0; i < 3; i++) begin : g_filter
			logic [1:0] sel;
			if (i == SRC_OC) begin : g_oc
				assign sel = state_reg.condCfg[OC_GLITCH_LSB +: 2];
			end else if (i == SRC_UV) begin : g_uv
				assign sel = state_reg.condCfg[UV_GLITCH_LSB +: 2];
			end else begin : g_ov
				assign sel = state_reg.condCfg[OV_GLITCH_LSB +: 2];
			end
			// filter code to cycle count
			always_comb begin
				case (sel)
					2'b00: glitchLimit[i] = 8'h00;
					2'b01: glitchLimit[i] = GLITCH_2US_CYC;
					2'b10: glitchLimit[i] = GLITCH_4US_CYC;
					2'b11: glitchLimit[i] = GLITCH_8US_CYC;
					default: glitchLimit[i] = 8'h00;
				endcase
			end
			// passes only once the fault has held for the limit
			assign filtFault[i] = rawFault[i] && (state_reg.glitchCnt[i] >= glitchLimit[i]);
		end
	endgenerate

	// one-to-clear strobes into the flag group
	always_comb begin
		flagW1c = 3'h0;
		if (regWrite && regAddr == ADDR_BUS_STATUS) begin
			flagW1c[SRC_OV] = regWrData[BUS_OV_FLAG_BIT];
			flagW1c[SRC_UV] = regWrData[BUS_UV_FLAG_BIT];
		end
		if (regWrite && regAddr == ADDR_CUR_STATUS) begin
			flagW1c[SRC_OC] = regWrData[OC_FLAG_BIT];
		end
	end
	assign clearAll = cmdStrobe && cmdCode == CMD_CLEAR_FAULTS;

	// per-pin source: latched flag when conditioned, raw level when bypassed
	assign srcA = (state_reg.flags & ~state_reg.condCfg[BYPASS_A_LSB +: 3])
		| (rawFault & state_reg.condCfg[BYPASS_A_LSB +: 3]);
	assign srcB = (state_reg.flags & ~state_reg.condCfg[BYPASS_B_LSB +: 3])
		| (rawFault & state_reg.condCfg[BYPASS_B_LSB +: 3]);
	assign activeA = state_reg.polForce[FORCE_A_BIT] || |(srcA & ~state_reg.maskA);
	assign activeB = state_reg.polForce[FORCE_B_BIT] || |(srcB & ~state_reg.maskB);

	// next state
	always_comb begin
		state_next = state_reg;
		// two-flop synchronisers on the comparator levels
		state_next.sync1 = {overvoltCmp, undervoltCmp, overcurrentCmp};
		state_next.sync2 = state_reg.sync1;
		// run-length counters, saturating
		for (int i = 0; i < 3; i++) begin
			if (!rawFault[i]) begin
				state_next.glitchCnt[i] = 8'h00;
			end else if (state_reg.glitchCnt[i] != 8'hFF) begin
				state_next.glitchCnt[i] = state_reg.glitchCnt[i] + 8'h01;
			end
		end
		// flags: a new fault wins over a clear in the same cycle
		if (clearAll) begin
			state_next.flags = filtFault;
		end else begin
			state_next.flags = (state_reg.flags & ~flagW1c) | filtFault;
		end
		// configuration writes
		if (regWrite) begin
			case (regAddr)
				ADDR_COND_CFG: state_next.condCfg = regWrData & COND_CFG_WMASK;
				ADDR_POL_FORCE: state_next.polForce = regWrData[3:0];
				ADDR_MASK_A: state_next.maskA = regWrData[2:0];
				ADDR_MASK_B: state_next.maskB = regWrData[2:0];
				default: state_next.condCfg = state_reg.condCfg;
			endcase
		end
		// read data, unmapped offsets answer zero
		if (regRead) begin
			case (regAddr)
				ADDR_BUS_STATUS: state_next.rdData = {8'h00, 1'b0, state_reg.flags[SRC_OV],
					state_reg.flags[SRC_UV], 5'h00};
				ADDR_CUR_STATUS: state_next.rdData = {8'h00, 2'b00, state_reg.flags[SRC_OC],
					5'h00};
				ADDR_COND_CFG: state_next.rdData = state_reg.condCfg;
				ADDR_POL_FORCE: state_next.rdData = {12'h000, state_reg.polForce};
				ADDR_MASK_A: state_next.rdData = {13'h0000, state_reg.maskA};
				ADDR_MASK_B: state_next.rdData = {13'h0000, state_reg.maskB};
				default: state_next.rdData = 16'h0000;
			endcase
		end
		// pin levels: level bit 1 means active high
		state_next.alertAOut = 1'b0;
		// open drain: active low pulls the wire down, active high releases it
		state_next.alertAOeN = state_reg.polForce[LEVEL_A_BIT] ? activeA : ~activeA;
		state_next.alertB = state_reg.polForce[LEVEL_B_BIT] ? activeB : ~activeB;
	end

	// state register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= '0;
			state_reg.condCfg <= COND_CFG_RESET;
			state_reg.polForce <= POL_FORCE_RESET;
			state_reg.maskA <= MASK_RESET;
			state_reg.maskB <= MASK_RESET;
			state_reg.flags <= FLAGS_RESET;
			state_reg.alertAOeN <= 1'b1;
			state_reg.alertB <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state register
	assign regRdData = state_reg.rdData;
	assign alertAPinOut = state_reg.alertAOut;
	assign alertAPinOeN = state_reg.alertAOeN;
	assign alertBPin = state_reg.alertB;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_filter_min_time: assert property (
		filtFault[SRC_OV] |-> state_reg.glitchCnt[SRC_OV] >= glitchLimit[SRC_OV])
		else $error("overvoltage passed before its filter time");
	a_filter_8us: assert property (
		(state_reg.condCfg[OV_GLITCH_LSB +: 2] == 2'b11 && filtFault[SRC_OV])
		|-> state_reg.glitchCnt[SRC_OV] >= GLITCH_8US_CYC)
		else $error("8us filter let a short fault through");
	a_cmp_off_silent: assert property (
		!state_reg.condCfg[OC_ON_BIT] |-> !rawFault[SRC_OC] && !filtFault[SRC_OC])
		else $error("disabled overcurrent comparator produced a fault");
	a_flag_latch: assert property (
		filtFault[SRC_OV] |=> state_reg.flags[SRC_OV] [*2] or
		(state_reg.flags[SRC_OV] ##1 $past(flagW1c[SRC_OV]) || $past(clearAll)))
		else $error("overvoltage flag did not latch");
	a_flag_hold: assert property (
		(state_reg.flags[SRC_UV] && !flagW1c[SRC_UV] && !clearAll) |=> state_reg.flags[SRC_UV])
		else $error("undervoltage flag dropped without a clear");
	a_w1c_clears: assert property (
		(flagW1c[SRC_OC] && !filtFault[SRC_OC]) |=> !state_reg.flags[SRC_OC])
		else $error("write one did not clear overcurrent flag");
	a_clear_all: assert property (
		(clearAll && filtFault == 3'h0) |=> state_reg.flags == 3'h0)
		else $error("clear faults command left a flag set");
	a_force_pin_b: assert property (
		state_reg.polForce[FORCE_B_BIT] |=> alertBPin == $past(state_reg.polForce[LEVEL_B_BIT]))
		else $error("forced alert b not at its active level");
	a_masked_quiet: assert property (
		(state_reg.maskA == 3'h7 && !state_reg.polForce[FORCE_A_BIT])
		|=> alertAPinOeN == !$past(state_reg.polForce[LEVEL_A_BIT]))
		else $error("fully masked alert a asserted");
	a_cur_read: assert property (
		(regRead && regAddr == ADDR_CUR_STATUS) |=> (regRdData & 16'hFFDF) == 16'h0000)
		else $error("unused current status bits read nonzero");
endmodule // facp_alert_cond

// file: tb/facp_far_side.sv
`timescale 1ns/1ps
// far side: comparator sources and the pulled-up open-drain alert wire
module facp_far_side (
	input wire logic [2:0] faultReq,
	input wire logic alertAPinOut,
	input wire logic alertAPinOeN,
	output logic overvoltCmp,
	output logic undervoltCmp,
	output logic overcurrentCmp,
	output logic alertAWire
);
	// comparator levels: bit 2 ov, bit 1 uv, bit 0 oc
	assign {overvoltCmp, undervoltCmp, overcurrentCmp} = faultReq;
	// a released wire rises through the pull-up
	assign alertAWire = alertAPinOeN ? 1'b1 : alertAPinOut;
endmodule // facp_far_side

// file: tb/fault_alert_conditioning_tb.sv
`timescale 1ns/1ps
module fault_alert_conditioning_tb;
	import facp_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic cmdStrobe = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] cmdCode = 8'h00;
	logic [15:0] regWrData = 16'h0000;
	logic [2:0] faultReq = 3'h0;
	logic [15:0] regRdData;
	logic ovC, uvC, ocC, aOut, aOeN, aWire, bPin;
	int n_mismatch = 0;
	int samples_checked = 0;
	facp_alert_cond u_dut (.clk(clk), .reset_n(reset_n), .overvoltCmp(ovC),
		.undervoltCmp(uvC), .overcurrentCmp(ocC), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWrData(regWrData), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode),
		.regRdData(regRdData), .alertAPinOut(aOut), .alertAPinOeN(aOeN), .alertBPin(bPin));
	facp_far_side u_far (.faultReq(faultReq), .alertAPinOut(aOut), .alertAPinOeN(aOeN),
		.overvoltCmp(ovC), .undervoltCmp(uvC), .overcurrentCmp(ocC), .alertAWire(aWire));
	// clock
	initial begin
		forever #20 clk = ~clk;
	end
	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		chk(regRdData, e);
	endtask
	task automatic cmd(input logic [7:0] c);
		@(posedge clk);
		cmdStrobe <= 1'b1;
		cmdCode <= c;
		@(posedge clk);
		cmdStrobe <= 1'b0;
	endtask
	// pin levels as {alert a wire, alert b}
	task automatic pins(input logic [15:0] e);
		@(negedge clk);
		chk(16'({aWire, bPin}), e);
	endtask
	task automatic fault(input logic [2:0] f, input int len);
		@(posedge clk);
		faultReq <= f;
		cyc(len);
		faultReq <= 3'h0;
	endtask
	task automatic t_regs();
		rd(ADDR_BUS_STATUS, 16'h0000);
		rd(ADDR_CUR_STATUS, 16'h0000);
		rd(ADDR_COND_CFG, 16'h0000);
		rd(ADDR_POL_FORCE, 16'h0000);
		rd(ADDR_MASK_A, 16'h0007);
		rd(ADDR_MASK_B, 16'h0007);
		rd(8'h55, 16'h0000);
		pins(16'h0003);
		wr(ADDR_COND_CFG, 16'hFFFF);
		rd(ADDR_COND_CFG, 16'h7FFF);
	endtask
	task automatic t_ov();
		wr(ADDR_COND_CFG, 16'h0002);
		wr(ADDR_MASK_A, 16'h0003);
		fault(3'b100, 2);
		cyc(8);
		rd(ADDR_BUS_STATUS, 16'h0040);
		pins(16'h0001);
		wr(ADDR_BUS_STATUS, 16'h0020);
		rd(ADDR_BUS_STATUS, 16'h0040);
		wr(ADDR_BUS_STATUS, 16'h0040);
		rd(ADDR_BUS_STATUS, 16'h0000);
		cyc(3);
		pins(16'h0003);
	endtask
	task automatic t_glitch(input logic [15:0] cfg, input logic [2:0] f, input int len,
		input logic [7:0] a, input logic [15:0] e);
		wr(ADDR_COND_CFG, cfg);
		fault(f, len);
		cyc(8);
		rd(a, e);
		cmd(CMD_CLEAR_FAULTS);
	endtask
	task automatic t_filter();
		t_glitch(16'h0021, 3'b010, 40, ADDR_BUS_STATUS, 16'h0000);
		t_glitch(16'h0021, 3'b010, 60, ADDR_BUS_STATUS, 16'h0020);
		t_glitch(16'h0012, 3'b100, 90, ADDR_BUS_STATUS, 16'h0000);
		t_glitch(16'h0012, 3'b100, 110, ADDR_BUS_STATUS, 16'h0040);
		t_glitch(16'h0184, 3'b001, 190, ADDR_CUR_STATUS, 16'h0000);
		t_glitch(16'h0184, 3'b001, 210, ADDR_CUR_STATUS, 16'h0020);
	endtask
	task automatic t_off_clear();
		wr(ADDR_COND_CFG, 16'h0000);
		fault(3'b111, 20);
		cyc(8);
		rd(ADDR_BUS_STATUS, 16'h0000);
		rd(ADDR_CUR_STATUS, 16'h0000);
		wr(ADDR_COND_CFG, 16'h0004);
		fault(3'b001, 3);
		cyc(8);
		cmd(8'h55);
		rd(ADDR_CUR_STATUS, 16'h0020);
		cmd(CMD_CLEAR_FAULTS);
		rd(ADDR_CUR_STATUS, 16'h0000);
	endtask
	task automatic t_bypass();
		wr(ADDR_COND_CFG, 16'h1004);
		wr(ADDR_MASK_B, 16'h0006);
		wr(ADDR_POL_FORCE, 16'h0008);
		cyc(1);
		pins(16'h0002);
		fault(3'b001, 6);
		cyc(1);
		pins(16'h0003);
		cyc(6);
		pins(16'h0002);
		rd(ADDR_CUR_STATUS, 16'h0020);
		cmd(CMD_CLEAR_FAULTS);
		wr(ADDR_COND_CFG, 16'h0204);
		wr(ADDR_MASK_A, 16'h0006);
		fault(3'b001, 6);
		cyc(1);
		pins(16'h0001);
		cyc(6);
		pins(16'h0003);
		cmd(CMD_CLEAR_FAULTS);
	endtask
	task automatic t_force();
		wr(ADDR_MASK_A, 16'h0007);
		wr(ADDR_MASK_B, 16'h0007);
		wr(ADDR_POL_FORCE, 16'h0003);
		cyc(1);
		pins(16'h0000);
		wr(ADDR_POL_FORCE, 16'h000C);
		cyc(1);
		pins(16'h0000);
		wr(ADDR_POL_FORCE, 16'h000F);
		rd(ADDR_POL_FORCE, 16'h000F);
		pins(16'h0003);
	endtask
	task automatic stop_test();
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		cyc(6);
		reset_n <= 1'b1;
		t_regs();
		t_ov();
		t_filter();
		t_off_clear();
		t_bypass();
		t_force();
		stop_test();
	end
	// watchdog, well beyond the expected run
	initial begin
		#400000;
		n_mismatch++;
		stop_test();
	end
endmodule // fault_alert_conditioning_tb
